// File: hw/cpfc_pkg.sv
// Constants for the cell protection FET control block.
package cpfc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Delay times in microseconds, as specified.
  localparam int unsigned OV_DELAY_US = 1_000_000;
  localparam int unsigned OV_REL_DELAY_US = 8_000;
  localparam int unsigned UV_DELAY_US = 24_000;
  localparam int unsigned UV_REL_DELAY_US = 4_000;
  localparam int unsigned OC_DELAY_US = 12_000;
  localparam int unsigned SC_DELAY_US = 400;
  localparam int unsigned OC_REL_DELAY_US = 4_000;
  // Cycle counts derived from the clock rate.
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned OV_CYC = OV_DELAY_US * CYC_PER_US;
  localparam int unsigned OV_REL_CYC = OV_REL_DELAY_US * CYC_PER_US;
  localparam int unsigned UV_CYC = UV_DELAY_US * CYC_PER_US;
  localparam int unsigned UV_REL_CYC = UV_REL_DELAY_US * CYC_PER_US;
  localparam int unsigned OC_CYC = OC_DELAY_US * CYC_PER_US;
  localparam int unsigned SC_CYC = SC_DELAY_US * CYC_PER_US;
  localparam int unsigned OC_REL_CYC = OC_REL_DELAY_US * CYC_PER_US;
  localparam int unsigned CNT_W = 26;
  localparam logic [CNT_W-1:0] CNT_RST = 26'h000_0000;
endpackage

// File: hw/cpfc_top.sv
// Fault qualification and gate control for a single-cell protector.
`timescale 1ns/1ns
module cpfc_top #(
  parameter int unsigned OV_CYC = cpfc_pkg::OV_CYC,
  parameter int unsigned OV_REL_CYC = cpfc_pkg::OV_REL_CYC,
  parameter int unsigned UV_CYC = cpfc_pkg::UV_CYC,
  parameter int unsigned UV_REL_CYC = cpfc_pkg::UV_REL_CYC,
  parameter int unsigned OC_CYC = cpfc_pkg::OC_CYC,
  parameter int unsigned SC_CYC = cpfc_pkg::SC_CYC,
  parameter int unsigned OC_REL_CYC = cpfc_pkg::OC_REL_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Comparator flags from the analog front end.
  input wire logic charging_i,
  input wire logic discharging_i,
  input wire logic over_voltage_i,
  input wire logic below_release_i,
  input wire logic under_voltage_i,
  input wire logic over_current_i,
  input wire logic short_circuit_i,
  // Gate and status outputs.
  output logic charge_fet_gate_o,
  output logic discharge_fet_gate_o,
  output logic release_pulldown_o,
  output logic standby_o
);
  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_UNDERV = 4'b0010,
    ST_OVERC = 4'b0100,
    ST_SHORT = 4'b1000
  } cpfc_dstate_type;

  logic rst_meta_r, rst_sync_r;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rstn = rst_sync_r;

  // Two-stage synchronisers for the seven pin inputs.
  logic [6:0] in_meta_r, in_sync_r;
  always_ff @(posedge mclk_i or negedge rstn) begin
    if (!rstn) begin
      in_meta_r <= 7'h00;
      in_sync_r <= 7'h00;
    end else begin
      in_meta_r <= {charging_i, discharging_i, over_voltage_i, below_release_i,
                    under_voltage_i, over_current_i, short_circuit_i};
      in_sync_r <= in_meta_r;
    end
  end
  wire chg = in_sync_r[6];
  wire dsg = in_sync_r[5];
  wire ov = in_sync_r[4];
  wire rel = in_sync_r[3];
  wire uv = in_sync_r[2];
  wire oc = in_sync_r[1];
  wire sc = in_sync_r[0];

  logic chg_off_r, chg_off_nxt;
  logic [cpfc_pkg::CNT_W-1:0] ccnt_r, ccnt_nxt;
  cpfc_dstate_type dst_r, dst_nxt;
  logic [cpfc_pkg::CNT_W-1:0] dcnt_r, dcnt_nxt;
  logic [cpfc_pkg::CNT_W-1:0] scnt_r, scnt_nxt;
  logic cg_r, dg_r, pd_r, sb_r;

  // Charge side.
  always_comb begin
    chg_off_nxt = chg_off_r;
    ccnt_nxt = cpfc_pkg::CNT_RST;
    if (!chg_off_r) begin
      if (chg && ov) begin
        ccnt_nxt = ccnt_r + 1'b1;
        if (ccnt_r == cpfc_pkg::CNT_W'(OV_CYC - 1)) begin
          chg_off_nxt = 1'b1;
          ccnt_nxt = cpfc_pkg::CNT_RST;
        end
      end
    end else if (rel) begin
      ccnt_nxt = ccnt_r + 1'b1;
      if (ccnt_r == cpfc_pkg::CNT_W'(OV_REL_CYC - 1)) begin
        chg_off_nxt = 1'b0;
        ccnt_nxt = cpfc_pkg::CNT_RST;
      end
    end
  end

  // Discharge side; short circuit runs its own timer beside overcurrent.
  always_comb begin
    dst_nxt = dst_r;
    dcnt_nxt = cpfc_pkg::CNT_RST;
    scnt_nxt = cpfc_pkg::CNT_RST;
    case (dst_r)
      ST_NORMAL: begin
        if (sc) begin
          scnt_nxt = scnt_r + 1'b1;
        end
        if (sc && scnt_r == cpfc_pkg::CNT_W'(SC_CYC - 1)) begin
          dst_nxt = ST_SHORT;
          scnt_nxt = cpfc_pkg::CNT_RST;
        end else if (oc) begin
          dcnt_nxt = dcnt_r + 1'b1;
          if (dcnt_r == cpfc_pkg::CNT_W'(OC_CYC - 1)) begin
            dst_nxt = ST_OVERC;
            dcnt_nxt = cpfc_pkg::CNT_RST;
          end
        end else if (dsg && uv) begin
          dcnt_nxt = dcnt_r + 1'b1;
          if (dcnt_r == cpfc_pkg::CNT_W'(UV_CYC - 1)) begin
            dst_nxt = ST_UNDERV;
            dcnt_nxt = cpfc_pkg::CNT_RST;
          end
        end
      end
      ST_UNDERV: begin
        if (!uv) begin
          dcnt_nxt = dcnt_r + 1'b1;
          if (dcnt_r == cpfc_pkg::CNT_W'(UV_REL_CYC - 1)) begin
            dst_nxt = ST_NORMAL;
            dcnt_nxt = cpfc_pkg::CNT_RST;
          end
        end
      end
      ST_OVERC, ST_SHORT: begin
        if (!oc) begin
          dcnt_nxt = dcnt_r + 1'b1;
          if (dcnt_r == cpfc_pkg::CNT_W'(OC_REL_CYC - 1)) begin
            dst_nxt = ST_NORMAL;
            dcnt_nxt = cpfc_pkg::CNT_RST;
          end
        end
      end
      default: begin
        dst_nxt = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn) begin
    if (!rstn) begin
      chg_off_r <= 1'b0;
      ccnt_r <= cpfc_pkg::CNT_RST;
      dst_r <= ST_NORMAL;
      dcnt_r <= cpfc_pkg::CNT_RST;
      scnt_r <= cpfc_pkg::CNT_RST;
      cg_r <= 1'b0;
      dg_r <= 1'b0;
      pd_r <= 1'b0;
      sb_r <= 1'b0;
    end else begin
      chg_off_r <= chg_off_nxt;
      ccnt_r <= ccnt_nxt;
      dst_r <= dst_nxt;
      dcnt_r <= dcnt_nxt;
      scnt_r <= scnt_nxt;
      cg_r <= !chg_off_nxt;
      dg_r <= (dst_nxt == ST_NORMAL);
      pd_r <= (dst_nxt == ST_OVERC) || (dst_nxt == ST_SHORT);
      sb_r <= (dst_nxt == ST_UNDERV);
    end
  end

  assign charge_fet_gate_o = cg_r;
  assign discharge_fet_gate_o = dg_r;
  assign release_pulldown_o = pd_r;
  assign standby_o = sb_r;

  sequence ov_run_s;
    (ccnt_r == cpfc_pkg::CNT_W'(OV_CYC - 1)) && !chg_off_r && chg && ov;
  endsequence
  ov_trip_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    ov_run_s |=> !charge_fet_gate_o) else $error("charge gate not dropped");
  ov_release_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    chg_off_r && rel && ccnt_r == cpfc_pkg::CNT_W'(OV_REL_CYC - 1) |=> charge_fet_gate_o)
    else $error("charge gate not restored");
  uv_trip_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    dst_r == ST_UNDERV |-> !discharge_fet_gate_o) else $error("gate high in undervoltage");
  uv_delay_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    dst_r == ST_UNDERV && $past(dst_r) == ST_NORMAL |-> $past(dcnt_r) ==
    cpfc_pkg::CNT_W'(UV_CYC - 1)) else $error("undervoltage entered early");
  sequence uv_rel_s;
    dst_r == ST_UNDERV && !uv && dcnt_r == cpfc_pkg::CNT_W'(UV_REL_CYC - 1);
  endsequence
  uv_release_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    uv_rel_s |=> discharge_fet_gate_o && !standby_o)
    else $error("discharge gate not restored");
  standby_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    dst_r == ST_UNDERV |-> standby_o && !release_pulldown_o) else $error("standby wrong");
  oc_trip_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    dst_r == ST_NORMAL && oc && !sc && dcnt_r == cpfc_pkg::CNT_W'(OC_CYC - 1)
    |=> dst_r == ST_OVERC) else $error("overcurrent not caught");
  sc_trip_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    dst_r == ST_NORMAL && sc && scnt_r == cpfc_pkg::CNT_W'(SC_CYC - 1)
    |=> dst_r == ST_SHORT && !discharge_fet_gate_o) else $error("short not caught");
  oc_release_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    (dst_r == ST_OVERC || dst_r == ST_SHORT) && oc |=> dcnt_r == cpfc_pkg::CNT_RST)
    else $error("release timer kept running");
  timer_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    !chg_off_r && !(chg && ov) |=> ccnt_r == cpfc_pkg::CNT_RST)
    else $error("detect timer kept running");
  sc_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn)
    dst_r == ST_NORMAL && !sc |=> scnt_r == cpfc_pkg::CNT_RST)
    else $error("short timer kept running");
endmodule

// File: bench/cpfc_fet_model.sv
// Behavioural model of the external charge and discharge FET pair.
`timescale 1ns/1ns
module cpfc_fet_model (
  // Gate drives from the protector.
  input wire logic chg_gate_i,
  input wire logic dsg_gate_i,
  // Conduction state of each FET.
  output logic chg_on_o,
  output logic dsg_on_o
);
  // An N-channel FET conducts while its gate is high.
  assign chg_on_o = chg_gate_i;
  assign dsg_on_o = dsg_gate_i;
endmodule

// File: bench/cpfc_top_bench.sv
// Self-checking bench for the cell protection FET control block.
`timescale 1ns/1ns
module cpfc_top_bench;
  localparam int unsigned OV = 20, OVR = 8, UV = 12, UVR = 4, OC = 10, SC = 5, OCR = 4;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic chg = 1'b0, dsg = 1'b0, ov = 1'b0, blw = 1'b1, uv = 1'b0, oc = 1'b0, sc = 1'b0;
  logic cg, dg, pd, sb, c_on, d_on;
  int error_cnt = 0;
  int tests_run = 0;
  always #10 mclk_i = ~mclk_i;
  cpfc_top #(.OV_CYC(OV), .OV_REL_CYC(OVR), .UV_CYC(UV), .UV_REL_CYC(UVR), .OC_CYC(OC),
    .SC_CYC(SC), .OC_REL_CYC(OCR)) u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .charging_i(chg), .discharging_i(dsg), .over_voltage_i(ov), .below_release_i(blw),
    .under_voltage_i(uv), .over_current_i(oc), .short_circuit_i(sc),
    .charge_fet_gate_o(cg), .discharge_fet_gate_o(dg), .release_pulldown_o(pd),
    .standby_o(sb));
  cpfc_fet_model u_fet (.chg_gate_i(cg), .dsg_gate_i(dg), .chg_on_o(c_on), .dsg_on_o(d_on));
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  // Current fault release shared by overcurrent and short circuit.
  task automatic rel_chk();
    oc = 1'b0;
    sc = 1'b0;
    wt(OCR);
    chk(dg, 1'b0);
    wt(6);
    chk(dg, 1'b1);
    chk(pd, 1'b0);
  endtask
  task automatic t_ov();
    chg = 1'b1;
    ov = 1'b1;
    wt(OV - 2);
    ov = 1'b0;
    wt(3);
    chk(c_on, 1'b1);
    ov = 1'b1;
    blw = 1'b0;
    wt(OV);
    chk(cg, 1'b1);
    wt(6);
    chk(c_on, 1'b0);
    ov = 1'b0;
    blw = 1'b1;
    wt(OVR);
    chk(cg, 1'b0);
    wt(6);
    chk(cg, 1'b1);
    chg = 1'b0;
    $display("test overvoltage done");
  endtask
  task automatic t_uv();
    dsg = 1'b1;
    uv = 1'b1;
    wt(UV - 2);
    uv = 1'b0;
    wt(3);
    chk(dg, 1'b1);
    uv = 1'b1;
    wt(UV);
    chk(dg, 1'b1);
    wt(6);
    chk(d_on, 1'b0);
    chk(sb, 1'b1);
    uv = 1'b0;
    wt(UVR);
    chk(dg, 1'b0);
    wt(6);
    chk(dg, 1'b1);
    chk(sb, 1'b0);
    $display("test undervoltage done");
  endtask
  task automatic t_oc();
    oc = 1'b1;
    wt(OC);
    chk(dg, 1'b1);
    wt(6);
    chk(d_on, 1'b0);
    chk(pd, 1'b1);
    rel_chk();
    $display("test overcurrent done");
  endtask
  task automatic t_sc();
    oc = 1'b1;
    sc = 1'b1;
    wt(SC);
    chk(dg, 1'b1);
    wt(6);
    chk(dg, 1'b0);
    chk(pd, 1'b1);
    rel_chk();
    $display("test short circuit done");
  endtask
  task automatic t_refuse();
    chg = 1'b0;
    dsg = 1'b0;
    ov = 1'b1;
    uv = 1'b1;
    wt(OV + 6);
    chk(cg, 1'b1);
    chk(dg, 1'b1);
    chk(sb, 1'b0);
    ov = 1'b0;
    uv = 1'b0;
    wt(6);
    $display("test refusal done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    wt(10);
    rstn_i = 1'b1;
    wt(6);
    chk(cg, 1'b1);
    chk(dg, 1'b1);
    chk(sb, 1'b0);
    chk(pd, 1'b0);
    t_ov();
    t_uv();
    t_oc();
    t_sc();
    t_refuse();
    summarize();
  end
  initial begin
    #40000;
    error_cnt++;
    summarize();
  end
endmodule
